// ### rtl/pin_event_detect.sv
// per-pin edge detector with sticky interrupt flags
`timescale 1ns/10ps
module pin_event_detect
  import pin_route_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  pin_event_if.detector ev
);

  typedef struct packed {
    logic [1:0] prev;
    logic [1:0] flag;
  } det_state_type;

  det_state_type state_q;
  det_state_type state_d;
  logic [1:0] hit;

  // ----------------------------------------------------------------
  // edge detection, one per pin
  // ----------------------------------------------------------------
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    assign hit[i] = ev.enable[i] & (ev.rising_sel[i] ? (ev.level[i] & ~state_q.prev[i])
                                                     : (~ev.level[i] & state_q.prev[i]));
  end

  always_comb begin
    state_d = state_q;
    state_d.prev = ev.level;
    // a new edge wins over a clear in the same cycle
    state_d.flag = (state_q.flag & ~ev.clear) | hit;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign ev.flag = state_q.flag;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_edge_sets_flag: assert property (@(posedge core_clk) disable iff (reset)
    hit[0] |=> ev.flag[0])
    else $error("pin0 edge did not set its flag");
  a_flag_holds_clear: assert property (@(posedge core_clk) disable iff (reset)
    ev.flag[1] && !ev.clear[1] |=> ev.flag[1])
    else $error("pin1 flag dropped without clear");
  a_disabled_no_flag: assert property (@(posedge core_clk) disable iff (reset)
    !ev.enable[1] && !ev.flag[1] |=> !ev.flag[1])
    else $error("pin1 flag rose while disabled");

endmodule

// ### rtl/port_j_low_pin_routing.sv
// routing of the two lowest port j pins between peripherals and gpio
`timescale 1ns/10ps
module port_j_low_pin_routing
  import pin_route_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [2:0] package_code,
  input wire logic second_serial_peripheral_en,
  input wire logic second_spi_master_out,
  input wire logic second_spi_master_out_oe,
  input wire logic second_spi_master_in,
  input wire logic second_spi_master_in_oe,
  input wire logic timer_channel6_io,
  input wire logic timer_channel6_oe,
  input wire logic pwm_channel6_out,
  input wire logic pwm_channel6_en,
  input wire logic [1:0] gpio_dir,
  input wire logic [1:0] general_purpose_output,
  input wire logic [1:0] pin_int_en,
  input wire logic [1:0] pin_int_rising,
  input wire logic [1:0] pin_int_clear,
  input wire logic [1:0] pin_in,
  output logic [1:0] pin_out,
  output logic [1:0] pin_oe,
  output logic [1:0] pin_level,
  output logic [1:0] pin_int_flag,
  output owner_type pin1_owner,
  output owner_type pin0_owner
);

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] out;
    logic [1:0] oe;
    owner_type own1;
    owner_type own0;
  } route_state_type;

  route_state_type state_q;
  route_state_type state_d;
  logic spi_bonded;
  logic is_48;
  pin_event_if ev ();

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // ports and state are sized for exactly two pins
  if (PIN_COUNT != 2) begin : g_bad_pin_count
    $error("pin router serves exactly two pins");
  end

  // ----------------------------------------------------------------
  // package decode
  // ----------------------------------------------------------------
  assign spi_bonded = (package_code != PKG_20) && (package_code != PKG_32);
  assign is_48 = (package_code == PKG_48);

  // ----------------------------------------------------------------
  // ownership and drive
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.sync1 = pin_in;
    state_d.sync2 = state_q.sync1;
    // pin1: spi master out, then timer (48 only), then gpio
    if (spi_bonded && second_serial_peripheral_en) begin
      state_d.own1 = own_spi;
      state_d.out[PIN1] = second_spi_master_out;
      state_d.oe[PIN1] = second_spi_master_out_oe;
    end else if (is_48 && timer_channel6_oe) begin
      state_d.own1 = own_tim;
      state_d.out[PIN1] = timer_channel6_io;
      state_d.oe[PIN1] = 1'b1;
    end else begin
      state_d.own1 = own_gpo;
      state_d.out[PIN1] = general_purpose_output[PIN1];
      state_d.oe[PIN1] = gpio_dir[PIN1];
    end
    // pin0: spi master in, then pwm (48 only), then gpio
    if (spi_bonded && second_serial_peripheral_en) begin
      state_d.own0 = own_spi;
      state_d.out[PIN0] = second_spi_master_in;
      state_d.oe[PIN0] = second_spi_master_in_oe;
    end else if (is_48 && pwm_channel6_en) begin
      state_d.own0 = own_pwm;
      state_d.out[PIN0] = pwm_channel6_out;
      state_d.oe[PIN0] = 1'b1;
    end else begin
      state_d.own0 = own_gpo;
      state_d.out[PIN0] = general_purpose_output[PIN0];
      state_d.oe[PIN0] = gpio_dir[PIN0];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q.sync1 <= PINS_RESET;
      state_q.sync2 <= PINS_RESET;
      state_q.out <= PINS_RESET;
      state_q.oe <= PINS_RESET;
      state_q.own1 <= own_gpo;
      state_q.own0 <= own_gpo;
    end else begin
      state_q <= state_d;
    end
  end

  assign pin_out = state_q.out;
  assign pin_oe = state_q.oe;
  assign pin_level = state_q.sync2;
  assign pin1_owner = state_q.own1;
  assign pin0_owner = state_q.own0;

  // ----------------------------------------------------------------
  // pin interrupts, sensed on the pin whatever its direction; disabled for PKG_20 and PKG_32
  // ----------------------------------------------------------------
  assign ev.level = state_q.sync2;
  assign ev.enable = spi_bonded ? pin_int_en : 2'h0;
  assign ev.rising_sel = pin_int_rising;
  assign ev.clear = pin_int_clear;
  assign pin_int_flag = ev.flag;

  pin_event_detect u_detect (
    .core_clk(core_clk),
    .reset(reset),
    .ev(ev)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_spi_owns_pin1: assert property (@(posedge core_clk) disable iff (reset)
    spi_bonded && second_serial_peripheral_en |=> pin1_owner == own_spi
      && pin_oe[1] == $past(second_spi_master_out_oe) && pin_out[1] == $past(second_spi_master_out))
    else $error("pin1 not driven by spi master out");
  a_timer_forces_out: assert property (@(posedge core_clk) disable iff (reset)
    is_48 && !second_serial_peripheral_en && timer_channel6_oe
      |=> pin_oe[1] && pin_out[1] == $past(timer_channel6_io))
    else $error("timer channel did not force pin1 output");
  a_spi_over_timer: assert property (@(posedge core_clk) disable iff (reset)
    is_48 && second_serial_peripheral_en && timer_channel6_oe |=> pin1_owner == own_spi)
    else $error("timer won over spi on pin1");
  a_no_timer_large: assert property (@(posedge core_clk) disable iff (reset)
    package_code == PKG_64_100 |=> pin1_owner != own_tim)
    else $error("timer routed to pin1 in large package");
  a_spi_owns_pin0: assert property (@(posedge core_clk) disable iff (reset)
    spi_bonded && second_serial_peripheral_en |=> pin0_owner == own_spi
      && pin_oe[0] == $past(second_spi_master_in_oe))
    else $error("pin0 not driven by spi master in");
  a_pwm_forces_out: assert property (@(posedge core_clk) disable iff (reset)
    is_48 && !second_serial_peripheral_en && pwm_channel6_en
      |=> pin_oe[0] && pin_out[0] == $past(pwm_channel6_out))
    else $error("pwm channel did not force pin0 output");
  a_spi_over_pwm: assert property (@(posedge core_clk) disable iff (reset)
    is_48 && second_serial_peripheral_en && pwm_channel6_en |=> pin0_owner == own_spi)
    else $error("pwm won over spi on pin0");
  a_no_pwm_large: assert property (@(posedge core_clk) disable iff (reset)
    package_code == PKG_64_100 |=> pin0_owner != own_pwm)
    else $error("pwm routed to pin0 in large package");
  a_gpio_fallback: assert property (@(posedge core_clk) disable iff (reset)
    !spi_bonded |=> pin_oe == $past(gpio_dir) && pin_out == $past(general_purpose_output))
    else $error("unowned pins do not follow gpio settings");
  a_small_no_int: assert property (@(posedge core_clk) disable iff (reset)
    !spi_bonded && pin_int_clear == 2'h3 |=> ##1 pin_int_flag == 2'h0)
    else $error("pin interrupt in small package");

  // ----------------------------------------------------------------
  // owner fallbacks and the full priority chain
  // ----------------------------------------------------------------
  // each owner checked with every higher one off
  a_spi_in_drive: assert property (@(posedge core_clk) disable iff (reset)
    spi_bonded && second_serial_peripheral_en |=> pin_out[0] == $past(second_spi_master_in))
    else $error("pin0 value not taken from spi master in");
  a_timer_owner: assert property (@(posedge core_clk) disable iff (reset)
    is_48 && !second_serial_peripheral_en && timer_channel6_oe |=> pin1_owner == own_tim)
    else $error("timer not owner of pin1 above gpio");
  a_pwm_owner: assert property (@(posedge core_clk) disable iff (reset)
    is_48 && !second_serial_peripheral_en && pwm_channel6_en |=> pin0_owner == own_pwm)
    else $error("pwm not owner of pin0 above gpio");
  a_gpio_pin1_48: assert property (@(posedge core_clk) disable iff (reset)
    is_48 && !second_serial_peripheral_en && !timer_channel6_oe |=> pin1_owner == own_gpo
      && pin_oe[1] == $past(gpio_dir[1]) && pin_out[1] == $past(general_purpose_output[1]))
    else $error("unowned pin1 does not follow gpio settings");
  a_gpio_pin0_48: assert property (@(posedge core_clk) disable iff (reset)
    is_48 && !second_serial_peripheral_en && !pwm_channel6_en |=> pin0_owner == own_gpo
      && pin_oe[0] == $past(gpio_dir[0]) && pin_out[0] == $past(general_purpose_output[0]))
    else $error("unowned pin0 does not follow gpio settings");
  a_large_pin1_gpio: assert property (@(posedge core_clk) disable iff (reset)
    package_code == PKG_64_100 && !second_serial_peripheral_en |=> pin1_owner == own_gpo
      && pin_oe[1] == $past(gpio_dir[1]))
    else $error("pin1 in large package not given to gpio");
  a_large_pin0_gpio: assert property (@(posedge core_clk) disable iff (reset)
    package_code == PKG_64_100 && !second_serial_peripheral_en |=> pin0_owner == own_gpo
      && pin_oe[0] == $past(gpio_dir[0]))
    else $error("pin0 in large package not given to gpio");
  a_small_no_spi: assert property (@(posedge core_clk) disable iff (reset)
    !spi_bonded |=> pin1_owner == own_gpo && pin0_owner == own_gpo)
    else $error("peripheral took a pin in small package");

  c_timer_owns: cover property (@(posedge core_clk) disable iff (reset) pin1_owner == own_tim);
  c_pwm_owns: cover property (@(posedge core_clk) disable iff (reset) pin0_owner == own_pwm);
  c_spi_owns: cover property (@(posedge core_clk) disable iff (reset) pin1_owner == own_spi);
  c_int_raised: cover property (@(posedge core_clk) disable iff (reset) pin_int_flag != 2'h0);
  // gpio driving a pin as output
  c_gpio_drives: cover property (@(posedge core_clk) disable iff (reset)
    pin_oe[1] && pin1_owner == own_gpo);

endmodule

// ### shared/pin_event_if.sv
// carrier between the router and the pin interrupt detector
`timescale 1ns/10ps
interface pin_event_if;
  logic [1:0] level;
  logic [1:0] enable;
  logic [1:0] rising_sel;
  logic [1:0] clear;
  logic [1:0] flag;

  modport router (output level, output enable, output rising_sel, output clear, input flag);
  modport detector (input level, input enable, input rising_sel, input clear, output flag);
endinterface

// ### shared/pin_route_pkg.sv
// constants for the low port j pin routing block
package pin_route_pkg;

  // ----------------------------------------------------------------
  // package codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PKG_20 = 3'h1;
  localparam logic [2:0] PKG_32 = 3'h2;
  localparam logic [2:0] PKG_48 = 3'h3;
  localparam logic [2:0] PKG_64_100 = 3'h4;

  // ----------------------------------------------------------------
  // pin positions and reset values
  // ----------------------------------------------------------------
  localparam int PIN_COUNT = 2;
  localparam int PIN0 = 0;
  localparam int PIN1 = 1;
  localparam logic [1:0] PINS_RESET = 2'h0;

  typedef enum logic [1:0] {
    own_spi,
    own_tim,
    own_pwm,
    own_gpo
  } owner_type;

endpackage

// ### tb/periph_model.sv
// behavioural spi, timer and pwm sources facing the pin router
`timescale 1ns/10ps
module periph_model (
  input wire logic [2:0] on,
  output logic mosi,
  output logic mosi_oe,
  output logic miso,
  output logic miso_oe,
  output logic tim_io,
  output logic tim_oe,
  output logic pwm_out,
  output logic pwm_en
);
  // ----------------------------------------------------------------
  // fixed levels chosen so that every owner gives a different pin
  // ----------------------------------------------------------------
  assign mosi = 1'b1;
  assign mosi_oe = 1'b1;
  assign miso = 1'b0;
  assign miso_oe = 1'b0;
  assign tim_io = 1'b0;
  assign tim_oe = on[1];
  assign pwm_out = 1'b0;
  assign pwm_en = on[2];
endmodule

// ### tb/tb_port_j_low_pin_routing.sv
// self-checking bench for the low port j pin routing block
`timescale 1ns/10ps
module tb_port_j_low_pin_routing
  import pin_route_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] pkg = PKG_48;
  logic [2:0] on = 3'h0;
  logic spi_en;
  logic [1:0] gdir = 2'h0;
  logic [1:0] int_en = 2'h0;
  logic [1:0] int_clr = 2'h0;
  logic [1:0] pin_in = 2'h0;
  logic mosi, mosi_oe, miso, miso_oe, tim_io, tim_oe, pwm_out, pwm_en;
  logic [1:0] pin_out, pin_oe, pin_level, pin_int_flag;
  owner_type pin1_owner, pin0_owner;
  int n_errors = 0;
  int checked = 0;

  always #25 core_clk = ~core_clk;
  always_comb spi_en = on[0];

  periph_model partner (.on(on), .mosi(mosi), .mosi_oe(mosi_oe), .miso(miso),
    .miso_oe(miso_oe), .tim_io(tim_io), .tim_oe(tim_oe), .pwm_out(pwm_out), .pwm_en(pwm_en));

  port_j_low_pin_routing dut (.core_clk(core_clk), .reset(reset), .package_code(pkg),
    .second_serial_peripheral_en(spi_en), .second_spi_master_out(mosi),
    .second_spi_master_out_oe(mosi_oe), .second_spi_master_in(miso),
    .second_spi_master_in_oe(miso_oe), .timer_channel6_io(tim_io),
    .timer_channel6_oe(tim_oe), .pwm_channel6_out(pwm_out), .pwm_channel6_en(pwm_en),
    .gpio_dir(gdir), .general_purpose_output(2'h3), .pin_int_en(int_en),
    .pin_int_rising(2'h3), .pin_int_clear(int_clr), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_level(pin_level), .pin_int_flag(pin_int_flag),
    .pin1_owner(pin1_owner), .pin0_owner(pin0_owner));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // sets package and sources, then compares owners and pin drive
  task automatic route_case(input logic [2:0] p, input logic [2:0] src);
    logic big;
    owner_type e1, e0;
    step(1);
    pkg <= p;
    on <= src;
    step(2);
    @(negedge core_clk);
    big = (p == PKG_48) || (p == PKG_64_100);
    e1 = (big && src[0]) ? own_spi : ((p == PKG_48 && src[1]) ? own_tim : own_gpo);
    e0 = (big && src[0]) ? own_spi : ((p == PKG_48 && src[2]) ? own_pwm : own_gpo);
    chk({4'h0, pin1_owner, pin0_owner}, {4'h0, e1, e0});
    chk({4'h0, pin_out, pin_oe}, {4'h0, e1 != own_tim, e0 == own_gpo,
      e1 != own_gpo, e0 == own_pwm});
  endtask

  task automatic test_reset;
    @(negedge core_clk);
    chk({4'h0, pin1_owner, pin0_owner}, {4'h0, own_gpo, own_gpo});
    chk({pin_out, pin_oe, pin_level, pin_int_flag}, 8'h00);
  endtask

  task automatic test_priority_48;
    for (int s = 0; s < 8; s++) route_case(PKG_48, s[2:0]);
  endtask

  task automatic test_large_pkg;
    for (int s = 0; s < 8; s++) route_case(PKG_64_100, s[2:0]);
  endtask

  task automatic test_small_pkg;
    for (int s = 0; s < 8; s += 3) route_case(PKG_20, s[2:0]);
    route_case(PKG_32, 3'h7);
  endtask

  // unowned pins driven as outputs follow gpio direction and data
  task automatic test_gpio_dir;
    step(1);
    pkg <= PKG_20;
    on <= 3'h7;
    gdir <= 2'h3;
    step(2);
    @(negedge core_clk);
    chk({6'h0, pin_oe}, 8'h03);
    chk({6'h0, pin_out}, 8'h03);
    step(1);
    gdir <= 2'h0;
  endtask

  // rising edges on both pins, flag sticks until cleared
  task automatic test_interrupt(input logic [2:0] p, input logic [1:0] exp);
    step(1);
    pkg <= p;
    on <= 3'h0;
    int_en <= 2'h3;
    pin_in <= 2'h0;
    int_clr <= 2'h3;
    step(6);
    int_clr <= 2'h0;
    step(2);
    pin_in <= 2'h3;
    step(7);
    @(negedge core_clk);
    chk({6'h0, pin_level}, 8'h03);
    chk({6'h0, pin_int_flag}, {6'h0, exp});
    step(1);
    int_clr <= 2'h3;
    step(1);
    int_clr <= 2'h0;
    step(2);
    @(negedge core_clk);
    chk({6'h0, pin_int_flag}, 8'h00);
    step(1);
    pin_in <= 2'h0;
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    test_reset();
    test_priority_48();
    test_large_pkg();
    test_small_pkg();
    test_gpio_dir();
    test_interrupt(PKG_48, 2'h3);
    test_interrupt(PKG_20, 2'h0);
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    print_verdict();
  end
endmodule
